/* eeprom_host_consts.vh */
`ifndef EEPROM_HOST_CONSTS_VH
`define EEPROM_HOST_CONSTS_VH

// ------------------------------------------------------------
// Device opcodes
// ------------------------------------------------------------
`define OP_READ          8'h03
`define OP_WRITE         8'h02
`define OP_LATCH_CLEAR   8'h04
`define OP_LATCH_SET     8'h06
`define OP_STATUS_READ   8'h05
`define OP_STATUS_WRITE  8'h01

// ------------------------------------------------------------
// Device status byte fields
// ------------------------------------------------------------
`define SR_PROTECT_PIN_EN 7
`define SR_BLOCK_HI       3
`define SR_BLOCK_LO       2
`define SR_LATCH          1
`define SR_BUSY           0

// ------------------------------------------------------------
// Controller register offsets (APB byte addresses)
// ------------------------------------------------------------
`define REG_CTRL     12'h000
`define REG_ADDR     12'h004
`define REG_WDATA    12'h008
`define REG_RDATA    12'h00c
`define REG_STAT     12'h010
`define REG_DIV      12'h014

// CTRL fields
`define CTRL_START   0
`define CTRL_OP_LSB  8
`define CTRL_OP_MSB  15
`define CTRL_LEN_LSB 16
`define CTRL_LEN_MSB 21
`define CTRL_PAUSE   24
`define CTRL_PROTECT 25

// STAT fields
`define STAT_BUSY    0
`define STAT_DONE    1
`define STAT_CNT_LSB 8
`define STAT_CNT_MSB 13

// Reset values
`define DIV_RESET    8'h04
`define CTRL_RESET   32'h0000_0000

// Link clock half period, in ns; divider counts pclk cycles
`define LINK_HALF_NS  200
`define PCLK_NS       50
`define LINK_HALF_CYC (`LINK_HALF_NS / `PCLK_NS)

`define BYTE_MAX     32

`endif

/* link_shifter.v */
`include "eeprom_host_consts.vh"

module link_shifter (
   // Clock and reset
   input  wire       pclk,
   input  wire       presetn,
   // Control
   input  wire [7:0] half_div,
   input  wire       go,
   input  wire       pause,
   input  wire [7:0] tx_byte,
   // Result
   output reg  [7:0] rx_byte_ff,
   output reg        done_ff,
   // Link pins
   output reg        sck_ff,
   output reg        mosi_ff,
   input  wire       miso
);

   reg [1:0] miso_sync_ff;
   reg [7:0] div_cnt_ff;
   reg [3:0] bit_cnt_ff;
   reg [7:0] sh_ff;
   reg       run_ff;

   wire [7:0] div_lim = (half_div == 8'h00) ? 8'h01 : half_div;
   wire       tick    = (div_cnt_ff + 8'h01 >= div_lim);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miso_sync_ff <= 2'b00;
      end else begin
         miso_sync_ff <= {miso_sync_ff[0], miso};
      end
   end

   // One byte, mode 0: data set while clock low, sampled on rising edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_ff <= 8'h00;
         bit_cnt_ff <= 4'h0;
         sh_ff      <= 8'h00;
         run_ff     <= 1'b0;
         sck_ff     <= 1'b0;
         mosi_ff    <= 1'b0;
         rx_byte_ff <= 8'h00;
         done_ff    <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (go && !run_ff) begin
            run_ff     <= 1'b1;
            sh_ff      <= tx_byte;
            mosi_ff    <= tx_byte[7];
            bit_cnt_ff <= 4'h0;
            div_cnt_ff <= 8'h00;
         end else if (run_ff) begin
            // Pause only holds the clock while low
            if (!(pause && !sck_ff)) begin
               if (tick) begin
                  div_cnt_ff <= 8'h00;
                  if (!sck_ff) begin
                     sck_ff <= 1'b1;
                  end else begin
                     sck_ff <= 1'b0;
                     // Synchronised miso sampled just before the fall
                     sh_ff  <= {sh_ff[6:0], miso_sync_ff[1]};
                     mosi_ff <= sh_ff[6];
                     if (bit_cnt_ff == 4'h7) begin
                        run_ff     <= 1'b0;
                        done_ff    <= 1'b1;
                        rx_byte_ff <= {sh_ff[6:0], miso_sync_ff[1]};
                     end
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
               end else begin
                  div_cnt_ff <= div_cnt_ff + 8'h01;
               end
            end
         end
      end
   end

endmodule

/* eeprom_host.v */
// Functional notes
// - Read opcode 03h and write opcode 02h are first byte after select.
// - Opcode 06h sets the write latch, 04h clears it.
// - Opcode 05h reads status byte; 01h writes following status byte.
// - All bytes go MSB first; device samples on rising clock edges.
// - Host keeps select low and hold high for whole operation; here hold drops mid-frame while the CTRL pause bit is set.
// - Read is opcode plus 16-bit address, top five bits ignored.
// - Read ends only when host raises select.
// - Latch set only by select rise after exactly eight bits.
// - Write sends opcode, 16-bit address, then up to page size bytes.
// - Write cycle starts only if select rises after a whole byte.
// - Host changes hold only while serial clock is low.
//
// Implementation choices: register access over APB and the address map.
`include "eeprom_host_consts.vh"

module eeprom_host (
   // APB slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata_ff,
   output reg         pready_ff,
   output reg         pslverr_ff,
   // Device link
   output reg         cs_n_ff,
   output reg         sck_ff,
   output reg         mosi_ff,
   input  wire        miso,
   output reg         hold_n_ff,
   output reg         wp_n_ff
);

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   localparam [5:0] ST_IDLE  = 6'b000001;
   localparam [5:0] ST_SETUP = 6'b000010;
   localparam [5:0] ST_SEND  = 6'b000100;
   localparam [5:0] ST_WAIT  = 6'b001000;
   localparam [5:0] ST_DESEL = 6'b010000;
   localparam [5:0] ST_GAP   = 6'b100000;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg  [7:0]  op_ff;
   reg  [5:0]  len_ff;
   reg         pause_ff;
   reg  [15:0] addr_ff;
   reg  [7:0]  div_ff;
   reg         busy_ff;
   reg         done_flag_ff;
   reg  [5:0]  state_ff;
   reg  [5:0]  byte_idx_ff;
   reg  [5:0]  data_cnt_ff;
   reg  [7:0]  gap_cnt_ff;
   reg         go_ff;
   reg  [7:0]  tx_ff;
   reg  [7:0]  wbuf [0:`BYTE_MAX-1];
   reg  [7:0]  rbuf [0:`BYTE_MAX-1];
   reg  [4:0]  rd_sel_ff;

   wire [7:0]  rx_byte;
   wire        sh_done;
   wire        sh_sck;
   wire        sh_mosi;
   reg         sh_pause;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // Register words sit back to back from the control register
   wire [5:0]  hit;
   genvar      gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_hit
         assign hit[gi] = (paddr == `REG_CTRL + 4 * gi);
      end
   endgenerate

   // Header byte count: opcode, plus two address bytes for array ops
   wire        is_array = (op_ff == `OP_READ) || (op_ff == `OP_WRITE);
   wire        is_rd    = (op_ff == `OP_READ) ||
                          (op_ff == `OP_STATUS_READ);
   wire [5:0]  hdr_len  = is_array ? 6'd3 : 6'd1;
   // Single-byte ops send no data; latch ops must stop at eight bits
   wire        no_data  = (op_ff == `OP_LATCH_SET) ||
                          (op_ff == `OP_LATCH_CLEAR);
   wire [5:0]  tot_len  = hdr_len + (no_data ? 6'd0 :
                          ((op_ff == `OP_STATUS_WRITE) ? 6'd1 : len_ff));
   wire        apb_acc  = psel && penable && !pready_ff;
   wire        apb_wr   = apb_acc && pwrite;
   wire        apb_rd   = apb_acc && !pwrite;
   wire        mapped   = |hit;
   wire        start    = apb_wr && (paddr == `REG_CTRL) &&
                          pwdata[`CTRL_START] && !busy_ff;
   wire [5:0]  len_req  = pwdata[`CTRL_LEN_MSB:`CTRL_LEN_LSB];
   // Longer bursts would overrun the 32-entry buffers
   wire [5:0]  len_cap  = (len_req > 6'h20) ? 6'h20 : len_req;

   // ------------------------------------------------------------
   // Serial byte engine
   // ------------------------------------------------------------
   link_shifter u_shift (
      .pclk       (pclk),
      .presetn    (presetn),
      .half_div   (div_ff),
      .go         (go_ff),
      .pause      (sh_pause),
      .tx_byte    (tx_ff),
      .rx_byte_ff (rx_byte),
      .done_ff    (sh_done),
      .sck_ff     (sh_sck),
      .mosi_ff    (sh_mosi),
      .miso       (miso)
   );

   always @* begin
      sh_pause = pause_ff;
   end

   // ------------------------------------------------------------
   // APB register access
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         op_ff      <= 8'h00;
         len_ff     <= 6'h00;
         pause_ff   <= 1'b0;
         wp_n_ff    <= 1'b1;
         addr_ff    <= 16'h0000;
         div_ff     <= `DIV_RESET;
         rd_sel_ff  <= 5'h00;
      end else begin
         pready_ff  <= apb_acc;
         pslverr_ff <= apb_acc && !mapped;
         if (apb_wr) begin
            case (paddr)
               `REG_CTRL: begin
                  pause_ff <= pwdata[`CTRL_PAUSE];
                  wp_n_ff  <= !pwdata[`CTRL_PROTECT];
                  if (!busy_ff) begin
                     op_ff  <= pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
                     len_ff <= len_cap;
                  end
               end
               // Top five address bits carry no meaning to the device
               `REG_ADDR:  addr_ff <= {5'h00, pwdata[10:0]};
               `REG_DIV:   div_ff  <= pwdata[7:0];
               `REG_WDATA: rd_sel_ff <= pwdata[12:8];
               default: begin
               end
            endcase
         end
         if (apb_rd) begin
            case (paddr)
               `REG_CTRL:  prdata_ff <= {6'h00, wp_n_ff ? 1'b0 : 1'b1,
                                         pause_ff, 2'h0, len_ff,
                                         op_ff, 7'h00, busy_ff};
               `REG_ADDR:  prdata_ff <= {16'h0000, addr_ff};
               `REG_RDATA: prdata_ff <= {24'h000000, rbuf[rd_sel_ff]};
               `REG_STAT:  prdata_ff <= {18'h00000, data_cnt_ff, 6'h00,
                                         done_flag_ff, busy_ff};
               `REG_DIV:   prdata_ff <= {24'h000000, div_ff};
               default:    prdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Data buffers
   // ------------------------------------------------------------
   // Write buffer: WDATA carries index in [12:8] and byte in [7:0]
   always @(posedge pclk) begin
      if (apb_wr && (paddr == `REG_WDATA)) begin
         wbuf[pwdata[12:8]] <= pwdata[7:0];
      end
   end

   // Read buffer filled from the link; longer reads wrap to slot 0
   always @(posedge pclk) begin
      if (sh_done && is_rd && (byte_idx_ff >= hdr_len)) begin
         rbuf[data_cnt_ff[4:0]] <= rx_byte;
      end
   end

   // ------------------------------------------------------------
   // Next byte for the link
   // ------------------------------------------------------------
   reg  [7:0]  nxt_tx;
   always @* begin
      nxt_tx = 8'h00;
      case (byte_idx_ff)
         6'h00:   nxt_tx = op_ff;
         // Status write takes its byte from slot 0
         6'h01:   nxt_tx = is_array ? addr_ff[15:8] : wbuf[0];
         6'h02:   nxt_tx = is_array ? addr_ff[7:0] : 8'h00;
         // Reads clock dummy zero bytes while the device answers, except slot 0 as a status read's first data byte
         default: nxt_tx = is_rd ? 8'h00 :
                           wbuf[byte_idx_ff[4:0] - 5'h03];
      endcase
   end

   // ------------------------------------------------------------
   // Transfer sequencer
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff     <= ST_IDLE;
         busy_ff      <= 1'b0;
         done_flag_ff <= 1'b0;
         cs_n_ff      <= 1'b1;
         byte_idx_ff  <= 6'h00;
         data_cnt_ff  <= 6'h00;
         gap_cnt_ff   <= 8'h00;
         go_ff        <= 1'b0;
         tx_ff        <= 8'h00;
      end else begin
         go_ff <= 1'b0;
         if (apb_rd && (paddr == `REG_STAT)) begin
            done_flag_ff <= 1'b0;
         end
         case (state_ff)
            ST_IDLE: begin
               if (start) begin
                  busy_ff     <= 1'b1;
                  cs_n_ff     <= 1'b0;
                  byte_idx_ff <= 6'h00;
                  data_cnt_ff <= 6'h00;
                  state_ff    <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               // Header then data, all MSB first
               tx_ff    <= nxt_tx;
               go_ff    <= 1'b1;
               state_ff <= ST_SEND;
            end
            ST_SEND: begin
               state_ff <= ST_WAIT;
            end
            ST_WAIT: begin
               if (sh_done) begin
                  if (byte_idx_ff >= hdr_len) begin
                     data_cnt_ff <= data_cnt_ff + 6'h01;
                  end
                  byte_idx_ff <= byte_idx_ff + 6'h01;
                  // Select rises only on a whole byte boundary
                  if (byte_idx_ff + 6'h01 >= tot_len) begin
                     state_ff <= ST_DESEL;
                  end else begin
                     state_ff <= ST_SETUP;
                  end
               end
            end
            ST_DESEL: begin
               // Ends read and commits writes
               cs_n_ff    <= 1'b1;
               gap_cnt_ff <= 8'h00;
               state_ff   <= ST_GAP;
            end
            ST_GAP: begin
               // Deselect time before next frame
               if (gap_cnt_ff >= `LINK_HALF_CYC) begin
                  busy_ff      <= 1'b0;
                  done_flag_ff <= 1'b1;
                  state_ff     <= ST_IDLE;
               end else begin
                  gap_cnt_ff <= gap_cnt_ff + 8'h01;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pause pin
   // ------------------------------------------------------------
   // Paused only inside a frame and with the clock low; outside a
   // frame the device must never see a pause with select high
   wire        in_frame = (state_ff == ST_SETUP) ||
                          (state_ff == ST_SEND) ||
                          (state_ff == ST_WAIT);
   // Resume raises the pin at least a cycle before the clock moves again
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_n_ff <= 1'b1;
      end else begin
         hold_n_ff <= !(pause_ff && !sh_sck && in_frame);
      end
   end

   // ------------------------------------------------------------
   // Link pins, straight from flops
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_ff  <= 1'b0;
         mosi_ff <= 1'b0;
      end else begin
         sck_ff  <= sh_sck;
         mosi_ff <= sh_mosi;
      end
   end

endmodule

/* eeprom_host_monitor.sv */
module eeprom_host_monitor (
   // Clock and reset
   input wire        pclk,
   input wire        presetn,
   // Register bus
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] prdata_ff,
   input wire        pready_ff,
   input wire        pslverr_ff,
   // Device link
   input wire        cs_n_ff,
   input wire        sck_ff,
   input wire        mosi_ff,
   input wire        hold_n_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   // --------
   // Bits clocked in the current frame
   // --------
   logic [9:0] nbit_ff;
   logic       sck_q_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nbit_ff  <= 10'h000;
         sck_q_ff <= 1'b0;
      end else begin
         sck_q_ff <= sck_ff;
         if (cs_n_ff)
            nbit_ff <= 10'h000;
         else if (sck_ff && !sck_q_ff)
            nbit_ff <= nbit_ff + 10'h001;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_next:
      assert property (psel && penable && !pready_ff |=> pready_ff)
      else $error("access not answered in one cycle");
   a_ready_single:
      assert property (pready_ff |=> !pready_ff)
      else $error("ready held longer than one cycle");
   a_err_zero:
      assert property (pslverr_ff |->
         pready_ff && (pwrite || prdata_ff == 32'h0))
      else $error("error answer without ready or with read data");
   a_sck_idle:
      assert property (cs_n_ff |-> !sck_ff)
      else $error("serial clock high while deselected");
   a_mosi_stable:
      assert property (sck_ff |-> $stable(mosi_ff))
      else $error("data changed while serial clock high");
   a_pause_clock_low:
      assert property ($changed(hold_n_ff) |-> !sck_ff)
      else $error("pause changed while serial clock high");
   a_pause_frozen:
      assert property (!hold_n_ff |-> !sck_ff && !cs_n_ff)
      else $error("clock ran or select dropped while paused");
   a_frame_whole_bytes:
      assert property ($rose(cs_n_ff) |->
         nbit_ff[2:0] == 3'h0 && nbit_ff != 10'h000 && !sck_ff)
      else $error("frame ended off a byte boundary");
   a_opcode_lead_zero:
      assert property (sck_ff && !sck_q_ff && nbit_ff < 10'h005 |->
         !mosi_ff)
      else $error("opcode top bits not zero");
   c_long_frame: cover property ($rose(cs_n_ff) && nbit_ff > 10'h018);
   c_paused: cover property ($fell(hold_n_ff));
   c_refused: cover property (pslverr_ff);
endmodule

bind eeprom_host eeprom_host_monitor mon (.pclk, .presetn, .psel,
   .penable, .pwrite, .prdata_ff, .pready_ff, .pslverr_ff, .cs_n_ff,
   .sck_ff,
   .mosi_ff, .hold_n_ff);

/* eeprom_dev_model.sv */
module eeprom_dev_model #(
   parameter int PAGE    = 32,
   parameter int BUSY_NS = 20000
) (
   // Link pins
   input  wire  cs_n,
   input  wire  sck,
   input  wire  mosi,
   input  wire  hold_n,
   input  wire  wp_n,
   output logic miso
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  mem [0:2047];
   logic [7:0]  sh, op, ob;
   logic [7:0]  wq [$];
   logic [10:0] a;
   logic        lat, bsy, pen, so, drv;
   logic [1:0]  bp;
   int          n;
   // Released line shows the inverse, so no stale bit reads as valid
   assign miso = (drv && hold_n) ? so : ~so;
   function automatic bit locked(input int w);
      return w >= (bp == 2'b11 ? 0 : bp == 2'b10 ? 'h400 :
                   bp == 2'b01 ? 'h600 : 'h800);
   endfunction
   function automatic int pg(input int k);
      return (a / PAGE) * PAGE + (a + k) % PAGE;
   endfunction
   task automatic commit;
      lat = 1'b0;
      bsy = 1'b1;
      bsy <= #(BUSY_NS) 1'b0;
   endtask
   initial begin
      for (int i = 0; i < 2048; i++)
         mem[i] = i[7:0] ^ 8'h5a;
      {lat, bsy, pen, bp, so, drv} = '0;
      n = 0;
   end
   always @(negedge cs_n) begin
      n = 0;
      wq.delete();
   end
   always @(posedge sck) if (!cs_n && hold_n) begin
      sh = {sh[6:0], mosi};
      n++;
      if (n == 8)
         op = sh;
      if (n == 16)
         a[10:8] = sh[2:0];
      if (n == 24)
         a[7:0] = sh;
      if (n > 24 && n % 8 == 0 && op == 8'h02)
         wq.push_back(sh);
   end
   always @(negedge sck) if (!cs_n && hold_n) begin
      // Array reads are dropped while a write cycle runs
      drv = (op == 8'h05 && n >= 8) || (op == 8'h03 && n >= 24 && !bsy);
      if (n % 8 == 0)
         ob = op == 8'h05 ? {pen, 3'b000, bp, lat, bsy} : mem[a];
      if (n % 8 == 0 && op == 8'h03 && n >= 24)
         a = a + 11'h001;
      so = ob[7 - n % 8];
   end
   // Unknown opcodes fall through every test below
   always @(posedge cs_n) begin
      drv = 1'b0;
      if (n == 8 && op == 8'h06)
         lat = 1'b1;
      if (n == 8 && op == 8'h04)
         lat = 1'b0;
      if (n == 16 && op == 8'h01 && lat && !bsy && !(pen && !wp_n)) begin
         {pen, bp} = {sh[7], sh[3:2]};
         commit();
      end
      if (n > 24 && n % 8 == 0 && op == 8'h02 && lat && !bsy) begin
         foreach (wq[k])
            if (!locked(pg(k)))
               mem[pg(k)] = wq[k];
         commit();
      end
   end
endmodule

/* tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
`include "eeprom_host_consts.vh"
   logic        pclk, presetn, psel, penable, pwrite, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rv;
   wire  [31:0] prdata_ff;
   wire         pready_ff, pslverr_ff, cs_n_ff, sck_ff, mosi_ff, miso;
   wire         hold_n_ff, wp_n_ff;
   int          bad_count, n_compared;
   eeprom_host DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata_ff, .pready_ff, .pslverr_ff, .cs_n_ff, .sck_ff,
      .mosi_ff, .miso, .hold_n_ff, .wp_n_ff);
   eeprom_dev_model dev (.cs_n(cs_n_ff), .sck(sck_ff), .mosi(mosi_ff),
      .hold_n(hold_n_ff), .wp_n(wp_n_ff), .miso(miso));
   initial pclk = 1'b0;
   always #25 pclk = ~pclk;
   function automatic logic [7:0] ival(input int i);
      return i[7:0] ^ 8'h5a;
   endfunction
   // --------
   // Bus and command tasks
   // --------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready_ff !== 1'b1);
      rv = prdata_ff;
      err = pslverr_ff;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_done;
      do begin
         xfer(1'b0, `REG_STAT, 32'h0);
      end while (rv[`STAT_DONE] !== 1'b1);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [5:0] len,
                      input logic [15:0] a, input logic prot);
      xfer(1'b1, `REG_ADDR, {16'h0, a});
      xfer(1'b1, `REG_CTRL, {6'h0, prot, 3'h0, len, op, 8'h01});
      wait_done();
   endtask
   task automatic rchk(input logic [4:0] i, input logic [7:0] e);
      xfer(1'b1, `REG_WDATA, {19'h0, i, 8'h00});
      xfer(1'b0, `REG_RDATA, 32'h0);
      chk({24'h0, rv[7:0]}, {24'h0, e});
   endtask
   task automatic put(input logic [4:0] i, input logic [7:0] b);
      xfer(1'b1, `REG_WDATA, {19'h0, i, b});
   endtask
   task automatic stat(input logic [7:0] e);
      cmd(`OP_STATUS_READ, 6'd1, 16'h0, 1'b0);
      rchk(5'd0, e);
   endtask
   task automatic idle;
      do begin
         cmd(`OP_STATUS_READ, 6'd1, 16'h0, 1'b0);
         xfer(1'b0, `REG_RDATA, 32'h0);
      end while (rv[0] !== 1'b0);
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #4000000;
      bad_count++;
      $display("CHECK FAILED t=%0t run hung", $time);
      wrap_up();
   end
   // --------
   // Test sequence
   // --------
   initial begin
      logic [15:0] pa [2];
      {psel, penable, pwrite, paddr, pwdata} = '0;
      bad_count = 0;
      n_compared = 0;
      pa = '{16'h05ff, 16'h0600};
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      xfer(1'b0, `REG_DIV, 32'h0);
      chk(rv, {24'h0, `DIV_RESET});
      xfer(1'b0, 12'h040, 32'h0);
      chk({rv[30:0], err}, 32'h1);
      stat(8'h00);
      cmd(`OP_LATCH_SET, 6'd0, 16'h0, 1'b0);
      stat(8'h02);
      cmd(`OP_LATCH_CLEAR, 6'd0, 16'h0, 1'b0);
      stat(8'h00);
      put(5'd0, 8'hc3);
      cmd(`OP_WRITE, 6'd1, 16'h0010, 1'b0);
      cmd(`OP_READ, 6'd1, 16'h0010, 1'b0);
      rchk(5'd0, ival(16));
      // Page write across the page end wraps to its start
      cmd(`OP_LATCH_SET, 6'd0, 16'h0, 1'b0);
      for (int i = 0; i < 4; i++)
         put(5'(i), 8'ha0 + 8'(i));
      cmd(`OP_WRITE, 6'd4, 16'h001e, 1'b0);
      stat(8'h01);
      idle();
      cmd(`OP_READ, 6'd4, 16'hfffe, 1'b0);
      for (int i = 0; i < 4; i++)
         rchk(5'(i), i < 2 ? ival(2046 + i) : 8'ha0 + 8'(i));
      cmd(`OP_READ, 6'd3, 16'h001e, 1'b0);
      for (int i = 0; i < 3; i++)
         rchk(5'(i), i < 2 ? 8'ha0 + 8'(i) : ival(32));
      // Status write keeps only the nonvolatile bits
      cmd(`OP_LATCH_SET, 6'd0, 16'h0, 1'b0);
      put(5'd0, 8'hf4);
      cmd(`OP_STATUS_WRITE, 6'd1, 16'h0, 1'b0);
      idle();
      stat(8'h84);
      foreach (pa[k]) begin
         cmd(`OP_LATCH_SET, 6'd0, 16'h0, 1'b0);
         put(5'd0, 8'h77);
         cmd(`OP_WRITE, 6'd1, pa[k], 1'b0);
         idle();
         cmd(`OP_READ, 6'd1, pa[k], 1'b0);
         rchk(5'd0, k ? ival(int'(pa[k])) : 8'h77);
      end
      cmd(`OP_LATCH_SET, 6'd0, 16'h0, 1'b1);
      put(5'd0, 8'h00);
      cmd(`OP_STATUS_WRITE, 6'd1, 16'h0, 1'b1);
      stat(8'h86);
      cmd(`OP_STATUS_WRITE, 6'd1, 16'h0, 1'b0);
      idle();
      stat(8'h00);
      // Pause in mid-frame, then resume
      xfer(1'b1, `REG_ADDR, 32'h0000_0100);
      xfer(1'b1, `REG_CTRL, 32'h0002_0301);
      repeat (150) @(posedge pclk);
      xfer(1'b1, `REG_CTRL, 32'h0102_0300);
      repeat (60) @(posedge pclk);
      chk({30'h0, hold_n_ff, sck_ff}, 32'h0);
      xfer(1'b1, `REG_CTRL, 32'h0002_0300);
      wait_done();
      chk({26'h0, rv[`STAT_CNT_MSB:`STAT_CNT_LSB]}, 32'h2);
      rchk(5'd0, ival(256));
      rchk(5'd1, ival(257));
      wrap_up();
   end
endmodule
